/* File: wdt_cfg.svh */
// Address map, key values, reset values and bit positions of the watchdog.
// Assumes a byte-wide register space with 12-bit addresses.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ****************************************
// Register addresses
// ****************************************
`define WDT_CTL_ADDR      12'hFF0
`define WDT_RLU_ADDR      12'hFF1
`define WDT_RLH_ADDR      12'hFF2
`define WDT_RLL_ADDR      12'hFF3

// ****************************************
// Unlock keys and counter values
// ****************************************
`define WDT_KEY_FIRST     8'h55
`define WDT_KEY_SECOND    8'hAA
`define WDT_RELOAD_RST    24'hFFFFFF
`define WDT_REFRESH_FLOOR 24'h000002
`define WDT_TERMINAL      24'h000001

// ****************************************
// Reset status register bit positions
// ****************************************
`define WDT_STAT_WDT_BIT  5
`define WDT_STAT_STOP_BIT 4

// ****************************************
// Timing: nominal oscillator rate; period in ms is reload / 10
// ****************************************
`define WDT_OSC_FREQ_HZ   10000

`endif

/* File: wdt_pkg.sv */
// Types shared by the watchdog modules.
// Assumes wdt_cfg.svh supplies the numeric constants.
package wdt_pkg;

	// ****************************************
	// Unlock sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		WDT_LOCKED,
		WDT_KEY_SEEN,
		WDT_OPEN
	} wdt_lock_t;

	typedef logic [23:0] wdt_count_t;

endpackage

/* File: wdt_sync_if.sv */
// Carrier between the oscillator synchroniser and the watchdog core.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
`default_nettype none

interface wdt_sync_if;
	logic level;
	logic rise;

	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

`default_nettype wire

/* File: wdt_sync.sv */
// Three-stage synchroniser with a qualified rising-edge pulse.
// Assumes the input is asynchronous to clk_sys_in.
`timescale 1ns/100ps
`default_nettype none

module wdt_sync (
	input  wire logic clk_sys_in,
	input  wire logic rst_b_in,
	input  wire logic clk_en_in,
	input  wire logic async_in,
	wdt_sync_if.src   sync_out
);

	logic       meta;
	logic [1:0] stage;
	logic       filt;
	logic       rise;
	wire        agree;
	wire        next_filt;

	// A change counts only when stages two and three agree
	assign agree     = (stage[0] == stage[1]);
	assign next_filt = agree ? stage[1] : filt;

	// First flop feeds only the second
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta  <= 1'b0;
			stage <= 2'h0;
			filt  <= 1'b0;
			rise  <= 1'b0;
		end else if (clk_en_in) begin
			meta  <= async_in;
			stage <= {stage[0], meta};
			filt  <= next_filt;
			rise  <= next_filt & ~filt;
		end
	end

	assign sync_out.level = filt;
	assign sync_out.rise  = rise;

endmodule

`default_nettype wire

/* File: wdt_core.sv */
// Watchdog core: 24-bit down counter, unlock sequencer, reset status.
// Assumes a CPU register port on the system clock and a free-running
// RC oscillator pin; option bits are static while out of reset.
//
// What this block does
// - Terminal count resets or interrupts, as configured
// - Counts on its own RC oscillator edges
// - Once on, counts continuously until refreshed
// - Enabled by refresh instruction or always-on option
// - Always-on option starts counting right after reset
// - 24-bit reload held in three byte registers
// - Reload is upper, high, low byte concatenated
// - Time-out milliseconds equal reload divided by ten
// - Refresh ignored once count reaches two
// - Reload bytes locked until 55 then AA
// - Unlock writes change no stored control bits
// - Control address reads back reset status
// - Refresh instruction loads reload into counter
// - Reload writes set reload, reads return count
// - Response option: zero interrupts, one resets
// - Non-always-on stops only on reset or recovery
// - Stop-mode time-out recovers, sets both flags
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"

module wdt_core (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	input  wire logic       clk_en_in,
	input  wire logic       wdt_osc_in,
	input  wire logic       always_on_option_in,
	input  wire logic       timeout_response_option_in,
	input  wire logic       refresh_instr_in,
	input  wire logic       stop_mode_in,
	input  wire logic [11:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	output logic            wdt_reset_req_out,
	output logic            wdt_irq_out,
	output logic            stop_recovery_out,
	output logic            wdt_running_out
);

	// ****************************************
	// Oscillator synchroniser
	// ****************************************
	wdt_sync_if osc_if ();

	// The RC clock is sampled, not used as a clock: one domain only
	wdt_sync u_osc_sync (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.clk_en_in  (clk_en_in),
		.async_in   (wdt_osc_in),
		.sync_out   (osc_if)
	);

	// ****************************************
	// State
	// ****************************************
	wdt_pkg::wdt_count_t count;
	wdt_pkg::wdt_count_t reload;
	wdt_pkg::wdt_lock_t  lock_state;
	wdt_pkg::wdt_lock_t  next_lock_state;
	logic                running;
	logic                opts_taken;
	logic                ao_latched;
	logic                res_latched;
	logic                flag_wdt;
	logic                flag_stop;

	// ****************************************
	// Address decode
	// ****************************************
	wire hit_ctl = (reg_addr_in == `WDT_CTL_ADDR);
	wire hit_rlu = (reg_addr_in == `WDT_RLU_ADDR);
	wire hit_rlh = (reg_addr_in == `WDT_RLH_ADDR);
	wire hit_rll = (reg_addr_in == `WDT_RLL_ADDR);
	wire hit_any = hit_ctl | hit_rlu | hit_rlh | hit_rll;

	wire wr_ctl  = reg_wr_in & hit_ctl;
	wire wr_open = reg_wr_in & (lock_state == wdt_pkg::WDT_OPEN);
	wire rd_ctl  = reg_rd_in & hit_ctl;

	// ****************************************
	// Unlock sequencer
	// ****************************************
	// Key writes only walk this machine; no control bits are stored
	always_comb begin
		next_lock_state = lock_state;
		if (reg_wr_in && hit_any) begin
			unique case (lock_state)
				wdt_pkg::WDT_LOCKED: begin
					if (wr_ctl && reg_wdata_in == `WDT_KEY_FIRST)
						next_lock_state = wdt_pkg::WDT_KEY_SEEN;
				end
				wdt_pkg::WDT_KEY_SEEN: begin
					// Any other watchdog register write in between breaks the pair
					if (wr_ctl && reg_wdata_in == `WDT_KEY_SECOND)
						next_lock_state = wdt_pkg::WDT_OPEN;
					else
						next_lock_state = wdt_pkg::WDT_LOCKED;
				end
				wdt_pkg::WDT_OPEN: begin
					// Low byte closes a reload update; a control write relocks
					if (wr_ctl || hit_rll)
						next_lock_state = wdt_pkg::WDT_LOCKED;
				end
			endcase
		end
	end

	// ****************************************
	// Counter decode
	// ****************************************
	// Enable comes from the refresh instruction or the always-on option
	wire enabled   = running | ~ao_latched;
	wire tick      = osc_if.rise & enabled;
	wire at_floor  = (count <= `WDT_REFRESH_FLOOR);
	// Once near terminal count a late refresh cannot rescue the time-out
	wire refresh_ok = refresh_instr_in & ~(running & at_floor);
	wire timeout   = tick & (count <= `WDT_TERMINAL) & ~refresh_ok;
	wire to_stop   = timeout & stop_mode_in;
	wire to_reset  = timeout & ~stop_mode_in & res_latched;
	wire to_irq    = timeout & ~res_latched;

	// Refresh loads reload; time-out reloads so the next period starts clean
	wire [23:0] next_count =
		(refresh_ok | timeout) ? reload :
		tick                   ? count - 24'h000001 :
		                         count;

	// Recovery drops a software-started watchdog; always-on never stops
	wire next_running = to_stop ? ~ao_latched : (running | refresh_ok | ~ao_latched);

	// ****************************************
	// Reload bytes
	// ****************************************
	// Reload is {upper, high, low}; the period in ms is that value / 10
	wire [23:0] next_reload = {
		(wr_open & hit_rlu) ? reg_wdata_in : reload[23:16],
		(wr_open & hit_rlh) ? reg_wdata_in : reload[15:8],
		(wr_open & hit_rll) ? reg_wdata_in : reload[7:0]
	};

	// ****************************************
	// Reset status and read data
	// ****************************************
	// Hardware set beats the clear-on-read of the same cycle
	wire next_flag_wdt  = timeout | (flag_wdt & ~rd_ctl);
	wire next_flag_stop = to_stop | (flag_stop & ~rd_ctl);

	wire [7:0] stat_byte = (8'h01 << `WDT_STAT_WDT_BIT) & {8{flag_wdt}}
		| (8'h01 << `WDT_STAT_STOP_BIT) & {8{flag_stop}};

	// Control address reads status; reload addresses read the live count
	wire [7:0] rd_mux =
		hit_ctl ? stat_byte :
		hit_rlu ? count[23:16] :
		hit_rlh ? count[15:8] :
		hit_rll ? count[7:0] :
		          8'h00;

	// ****************************************
	// Option capture
	// ****************************************
	// Options are caught on the first enabled edge after release,
	// never through the asynchronous reset path
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			opts_taken  <= 1'b0;
			ao_latched  <= 1'b1;
			res_latched <= 1'b1;
		end else if (clk_en_in && !opts_taken) begin
			opts_taken  <= 1'b1;
			ao_latched  <= always_on_option_in;
			res_latched <= timeout_response_option_in;
		end
	end

	// ****************************************
	// Counter, reload and lock registers
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count      <= `WDT_RELOAD_RST;
			reload     <= `WDT_RELOAD_RST;
			running    <= 1'b0;
			lock_state <= wdt_pkg::WDT_LOCKED;
		end else if (clk_en_in && opts_taken) begin
			count      <= next_count;
			reload     <= next_reload;
			running    <= next_running;
			lock_state <= next_lock_state;
		end
	end

	// ****************************************
	// Status flags and outputs
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flag_wdt          <= 1'b0;
			flag_stop         <= 1'b0;
			reg_rdata_out     <= 8'h00;
			wdt_reset_req_out <= 1'b0;
			wdt_irq_out       <= 1'b0;
			stop_recovery_out <= 1'b0;
			wdt_running_out   <= 1'b0;
		end else if (clk_en_in) begin
			flag_wdt          <= next_flag_wdt;
			flag_stop         <= next_flag_stop;
			reg_rdata_out     <= reg_rd_in ? rd_mux : 8'h00;
			wdt_reset_req_out <= to_reset;
			wdt_irq_out       <= to_irq;
			stop_recovery_out <= to_stop;
			wdt_running_out   <= opts_taken & enabled;
		end
	end

endmodule

`default_nettype wire

/* File: wdt_core_props.sv */
// Port checks for the watchdog core.
// Assumes clk_en_in held high by the bench.
`timescale 1ns/100ps
`default_nettype none
module wdt_props (
	input wire logic        clk_sys_in,
	input wire logic        rst_b_in,
	input wire logic        always_on_option_in,
	input wire logic        timeout_response_option_in,
	input wire logic        refresh_instr_in,
	input wire logic        stop_mode_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire logic        wdt_reset_req_out,
	input wire logic        wdt_irq_out,
	input wire logic        stop_recovery_out,
	input wire logic        wdt_running_out
);
	// ****************
	// Relations
	// ****************
	// One domain, so clock and reset are set once
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	property p_rd; reg_rdata_out != 8'h00 |-> $past(reg_rd_in); endproperty
	a_rd: assert property (p_rd) else $error("data without read");
	property p_stat; reg_rd_in && reg_addr_in == 12'hFF0 |=> (reg_rdata_out & 8'hCF) == 8'h00; endproperty
	a_stat: assert property (p_stat) else $error("status spare bits");
	property p_ref; refresh_instr_in |-> ##2 wdt_running_out; endproperty
	a_ref: assert property (p_ref) else $error("refresh did not start");
	property p_ao; !always_on_option_in && $past(wdt_running_out) |-> wdt_running_out; endproperty
	a_ao: assert property (p_ao) else $error("always-on stopped");
	property p_one; wdt_reset_req_out |=> !wdt_reset_req_out; endproperty
	a_one: assert property (p_one) else $error("reset pulse long");
	property p_ropt; wdt_reset_req_out |-> timeout_response_option_in && !stop_mode_in; endproperty
	a_ropt: assert property (p_ropt) else $error("reset in wrong mode");
	property p_iopt; wdt_irq_out |-> !timeout_response_option_in; endproperty
	a_iopt: assert property (p_iopt) else $error("irq in wrong mode");
	property p_rec; stop_recovery_out |-> stop_mode_in ##1 !stop_recovery_out; endproperty
	a_rec: assert property (p_rec) else $error("bad recovery pulse");
	property p_run; wdt_reset_req_out |-> $past(wdt_running_out); endproperty
	a_run: assert property (p_run) else $error("time-out while off");
	c_rst: cover property (wdt_reset_req_out);
	c_irq: cover property (wdt_irq_out);
	c_rec: cover property (stop_recovery_out);
endmodule
bind wdt_core wdt_props i_props (.clk_sys_in, .rst_b_in, .always_on_option_in, .timeout_response_option_in,
	.refresh_instr_in, .stop_mode_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .wdt_reset_req_out,
	.wdt_irq_out, .stop_recovery_out, .wdt_running_out);
`default_nettype wire

/* File: tb_wdt_core.sv */
// Self-checking bench for the watchdog core.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_wdt_core;
	logic        clk_sys_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        ao = 1'b1;
	logic        resp = 1'b1;
	logic        refresh = 1'b0;
	logic        stop = 1'b0;
	logic        osc = 1'b0;
	logic [11:0] addr = 12'h000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata, v;
	logic        rst_req, irq, recov, running;
	logic [2:0]  cases [4] = '{3'b110, 3'b100, 3'b011, 3'b101};
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          n_rst, n_irq, n_rec;
	logic [23:0] m_reload;
	// Behavioural model: live count, run state, time-outs, pending status events
	int          m_count;
	bit          m_run;
	int          m_to;
	bit          m_stat_q [$];
	wdt_core i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1), .wdt_osc_in(osc),
		.always_on_option_in(ao), .timeout_response_option_in(resp), .refresh_instr_in(refresh),
		.stop_mode_in(stop), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .wdt_reset_req_out(rst_req), .wdt_irq_out(irq),
		.stop_recovery_out(recov), .wdt_running_out(running));
	// ****************
	// Clock, hang guard
	// ****************
	initial forever #4 clk_sys_in = ~clk_sys_in;
	// A stuck handshake would otherwise run forever
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			summarize();
		end
	end
	// ****************
	// Tasks
	// ****************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Options change only inside reset; they are sampled on the first edge after release
	task automatic do_reset(input logic a_on, input logic r);
		rst_b_in = 1'b0;
		ao = a_on;
		resp = r;
		stop = 1'b0;
		m_count = 32'h00FFFFFF;
		m_reload = 24'hFFFFFF;
		m_run = !a_on;
		m_stat_q.delete();
		cyc(6);
		rst_b_in = 1'b1;
		cyc(3);
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		d = rdata;
		cyc(1);
	endtask
	task automatic rd_count(input logic [23:0] exp);
		logic [7:0] u, h, l;
		rd_reg(12'hFF1, u);
		rd_reg(12'hFF2, h);
		rd_reg(12'hFF3, l);
		check("count", {u, h, l}, exp);
	endtask
	task automatic load(input logic [23:0] val);
		wr_reg(12'hFF0, 8'h55);
		wr_reg(12'hFF0, 8'hAA);
		wr_reg(12'hFF1, val[23:16]);
		wr_reg(12'hFF2, val[15:8]);
		wr_reg(12'hFF3, val[7:0]);
		m_reload = val;
	endtask
	task automatic kick;
		// Model: a refresh near terminal count is lost while running
		if (!(m_run && m_count <= 32'h00000002)) begin
			m_count = int'(m_reload);
			m_run = 1'b1;
		end
		refresh = 1'b1;
		cyc(1);
		refresh = 1'b0;
		cyc(1);
	endtask
	// Oscillator periods, counting every output pulse seen
	task automatic tick(input int n);
		repeat (n) begin
			// Model: one count per period, reload and log an event on time-out
			if (m_run && m_count <= 32'h00000001) begin
				m_count = int'(m_reload);
				m_to++;
				m_stat_q.push_back(stop);
				if (stop && ao)
					m_run = 1'b0;
			end else if (m_run) begin
				m_count--;
			end
			for (int i = 0; i < 12; i++) begin
				osc = (i < 6);
				cyc(1);
				n_rst += int'(rst_req === 1'b1);
				n_irq += int'(irq === 1'b1);
				n_rec += int'(recov === 1'b1);
			end
		end
	endtask
	// Model status byte: time-out flag if any event, stop flag if any in stop
	function automatic logic [23:0] m_stat();
		logic st;
		st = 1'b0;
		foreach (m_stat_q[j])
			st |= m_stat_q[j];
		return {16'h0000, 2'b00, m_stat_q.size() > 0, st, 4'h0};
	endfunction
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ****************
	// Tests
	// ****************
	initial begin
		void'($urandom(32'h89b928f4));
		do_reset(1'b1, 1'b1);
		rd_count(24'hFFFFFF);
		rd_reg(12'hFF4, v);
		check("unmapped", 24'(v), 24'h000000);
		wr_reg(12'hFF3, 8'h12);
		wr_reg(12'hFF0, 8'h55);
		wr_reg(12'hFF1, 8'h34);
		wr_reg(12'hFF0, 8'hAA);
		wr_reg(12'hFF2, 8'h56);
		kick();
		rd_count(24'hFFFFFF);
		repeat (4) begin
			load(24'($urandom_range(32'h00FFFFFF, 32'h00000004)));
			kick();
			rd_count(24'(m_count));
		end
		$display("test reload done");
		// Reload 4: two ticks reach 2, the refresh is then ignored
		foreach (cases[k]) begin
			do_reset(cases[k][2], cases[k][1]);
			stop = cases[k][0];
			check("running", 24'(running), 24'(m_run));
			load(24'h000004);
			kick();
			check("running", 24'(running), 24'h000001);
			n_rst = 0;
			n_irq = 0;
			n_rec = 0;
			m_to = 0;
			tick(2);
			kick();
			tick(2);
			check("reset req", 24'(n_rst), 24'(m_to) & {24{cases[k][1] & ~cases[k][0]}});
			check("irq", 24'(n_irq), 24'(m_to) & {24{~cases[k][1]}});
			check("recovery", 24'(n_rec), 24'(m_to) & {24{cases[k][0]}});
			rd_reg(12'hFF0, v);
			check("status", 24'(v), m_stat());
			m_stat_q.delete();
			rd_reg(12'hFF0, v);
			check("status", 24'(v), m_stat());
			check("running", 24'(running), 24'(m_run));
			rd_count(24'(m_count));
			$display("test time-out %0d done", k);
		end
		summarize();
	end
endmodule
`default_nettype wire
